// ==== dshp_pkg.sv ====
// Shared constants for the display serial host port.
package dshp_pkg;

  // Bit index of the last bit in a write frame, per variant.
  localparam logic [3:0] LAST_BIT_4W = 4'h7;
  localparam logic [3:0] LAST_BIT_3W = 4'h8;

  // Bits still to send after the bit that a load puts on the line.
  localparam logic [2:0] RD_BITS_AFTER_LOAD = 3'h7;

  // Byte returned when the user side has nothing ready at a load.
  localparam logic [7:0] RD_FILL_BYTE = 8'h00;

  // Receive FIFO shape: one type bit above the byte, four entries.
  localparam int RX_WIDTH = 9;
  localparam int RX_DEPTH = 4;

  // Values after reset.
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [2:0] RD_BITS_RST = 3'h0;

  // Core clock and the fastest serial clocks the host may use.
  localparam int CLK_KHZ = 200000;
  localparam int SCLK_WR_MAX_KHZ = 20000;
  localparam int SCLK_RD_MAX_KHZ = 2500;

  // Core cycles in the shortest serial clock period, rounded down.
  localparam int SCLK_WR_MIN_CYC = CLK_KHZ / SCLK_WR_MAX_KHZ;
  localparam int SCLK_RD_MIN_CYC = CLK_KHZ / SCLK_RD_MAX_KHZ;

  // Link state of the port.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_READ
  } dshp_state_t;

endpackage : dshp_pkg

// ==== dshp_top.sv ====
// Serial host port of the display controller, with its receive FIFO.
// Function
// - The strap picks the variant: low is 4-wire with a select pin, high is 3-wire with 9-bit frames.
// - In 4-wire writes the data line is shifted in on each rising clock edge, most significant bit first.
// - A finished 4-wire byte goes out as a command when the select pin is low and as data when it is high.
// - Each read byte goes out most significant bit first, one bit per falling clock edge, except the first D7 of a 4-wire read, put out when select rises.
// - A read may return several bytes in a row and ends when the host raises chip select.
// - A 3-wire write frame is a type bit then bits seven to zero, type 0 marking a command and 1 data.
// - A 3-wire read is a command frame with type 0, then one type bit of 1, then data out on falling edges.
`timescale 1ns/1ps
`default_nettype none

module dshp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic push;
  logic pop;
  logic full;
  logic empty;

  // One extra pointer bit tells a full buffer from an empty one.
  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) &&
                (wptr_reg[AW] != rptr_reg[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem[rptr_reg[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg <= '0;
    end else if (push) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rptr_reg <= '0;
    end else if (pop) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end

endmodule : dshp_fifo

module dshp_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial link pins.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dc_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic bus_variant_strap_i,
  // Received bytes toward the command decoder.
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_byte_o,
  output logic rx_is_data_o,
  output logic rx_overrun_o,
  // Read data from the register side.
  input wire logic read_arm_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  // Status.
  output logic variant_3wire_o
);

  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic dc_s1_reg;
  logic dc_s2_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic variant3_reg;
  dshp_pkg::dshp_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] in_sh_reg;
  logic after_cmd_reg;
  logic [6:0] out_sh_reg;
  logic [2:0] rd_bits_reg;
  logic overrun_reg;
  logic sda_out_reg;
  logic cs_active;
  logic rise;
  logic fall;
  logic [3:0] last_bit;
  logic enter_rd4;
  logic enter_rd3;
  logic in_shift;
  logic byte_done;
  logic [7:0] new_byte;
  logic new_is_data;
  logic load;
  logic shift_out;
  logic [7:0] load_byte;
  logic push_ready;
  logic [8:0] pop_word;

  // Every pin passes two flops; edges are found between the second
  // and a third flop so the first stage feeds nothing else.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      dc_s1_reg <= 1'b0;
      dc_s2_reg <= 1'b0;
      sda_s1_reg <= 1'b0;
      sda_s2_reg <= 1'b0;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= cs_n_i;
      cs_s2_reg <= cs_s1_reg;
      dc_s1_reg <= dc_i;
      dc_s2_reg <= dc_s1_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      strap_s1_reg <= bus_variant_strap_i;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  assign cs_active = !cs_s2_reg;
  assign rise = sclk_s2_reg && !sclk_s3_reg;
  assign fall = !sclk_s2_reg && sclk_s3_reg;

  // The strap is followed only between frames, so a frame never
  // changes its variant halfway.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      variant3_reg <= 1'b0;
    end else if (!cs_active) begin
      variant3_reg <= strap_s2_reg;
    end
  end

  assign variant_3wire_o = variant3_reg;
  assign last_bit = variant3_reg ? dshp_pkg::LAST_BIT_3W
                                 : dshp_pkg::LAST_BIT_4W;
  assign in_shift = (state_reg == dshp_pkg::ST_SHIFT);

  // A read starts only when the decoder has judged the last command
  // to be a read; the port itself knows no command semantics.
  assign enter_rd4 = in_shift && !variant3_reg && after_cmd_reg &&
                     (bit_cnt_reg == dshp_pkg::BIT_CNT_RST) &&
                     read_arm_i && dc_s2_reg;
  assign enter_rd3 = in_shift && variant3_reg && after_cmd_reg &&
                     (bit_cnt_reg == dshp_pkg::BIT_CNT_RST) &&
                     read_arm_i && rise && sda_s2_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= dshp_pkg::ST_IDLE;
    end else if (!cs_active) begin
      state_reg <= dshp_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        dshp_pkg::ST_IDLE: begin
          state_reg <= dshp_pkg::ST_SHIFT;
        end
        dshp_pkg::ST_SHIFT: begin
          if (enter_rd4 || enter_rd3) begin
            state_reg <= dshp_pkg::ST_READ;
          end
        end
        dshp_pkg::ST_READ: begin
          state_reg <= dshp_pkg::ST_READ;
        end
      endcase
    end
  end

  // Write path.
  assign byte_done = in_shift && rise && !enter_rd3 &&
                     (bit_cnt_reg == last_bit);
  assign new_byte = {in_sh_reg[6:0], sda_s2_reg};
  // In 4-wire mode the select pin is taken at the last bit; the host
  // keeps it steady over the byte, so any bit would give the same.
  assign new_is_data = variant3_reg ? in_sh_reg[7] : dc_s2_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_reg <= dshp_pkg::BIT_CNT_RST;
    end else if (!in_shift) begin
      bit_cnt_reg <= dshp_pkg::BIT_CNT_RST;
    end else if (rise && !enter_rd3) begin
      if (bit_cnt_reg == last_bit) begin
        bit_cnt_reg <= dshp_pkg::BIT_CNT_RST;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_sh_reg <= dshp_pkg::SHIFT_RST;
    end else if (in_shift && rise) begin
      in_sh_reg <= {in_sh_reg[6:0], sda_s2_reg};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      after_cmd_reg <= 1'b0;
    end else if (!cs_active) begin
      after_cmd_reg <= 1'b0;
    end else if (byte_done) begin
      after_cmd_reg <= !new_is_data;
    end
  end

  // The host cannot be stalled, so a byte that meets a full FIFO is
  // dropped and flagged; the decoder must drain faster than a byte
  // time of 8 serial clocks in 4-wire and 9 in 3-wire.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= byte_done && !push_ready;
    end
  end

  assign rx_overrun_o = overrun_reg;

  dshp_fifo #(
    .WIDTH(dshp_pkg::RX_WIDTH),
    .DEPTH(dshp_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(byte_done),
    .in_ready_o(push_ready),
    .in_data_i({new_is_data, new_byte}),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(pop_word)
  );

  assign rx_is_data_o = pop_word[8];
  assign rx_byte_o = pop_word[7:0];

  // Read path: 4-wire puts D7 out as soon as select rises, 3-wire on
  // the falling edge that closes the type bit.
  assign load = enter_rd4 || ((state_reg == dshp_pkg::ST_READ) && fall &&
                (rd_bits_reg == dshp_pkg::RD_BITS_RST));
  assign shift_out = (state_reg == dshp_pkg::ST_READ) && fall &&
                     (rd_bits_reg != dshp_pkg::RD_BITS_RST);
  assign load_byte = tx_valid_i ? tx_byte_i : dshp_pkg::RD_FILL_BYTE;
  assign tx_ready_o = load;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_bits_reg <= dshp_pkg::RD_BITS_RST;
    end else if (!cs_active || enter_rd3) begin
      rd_bits_reg <= dshp_pkg::RD_BITS_RST;
    end else if (load) begin
      rd_bits_reg <= dshp_pkg::RD_BITS_AFTER_LOAD;
    end else if (shift_out) begin
      rd_bits_reg <= rd_bits_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_sh_reg <= 7'h00;
      sda_out_reg <= 1'b0;
    end else if (load) begin
      out_sh_reg <= load_byte[6:0];
      sda_out_reg <= load_byte[7];
    end else if (shift_out) begin
      out_sh_reg <= {out_sh_reg[5:0], 1'b0};
      sda_out_reg <= out_sh_reg[6];
    end
  end

  assign sda_o = sda_out_reg;
  assign sda_oe_o = (state_reg == dshp_pkg::ST_READ);

endmodule : dshp_top

`default_nettype wire

// ==== dshp_checker.sv ====
// Concurrent checks on the serial host port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module dshp_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial link pins.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic bus_variant_strap_i,
  // Byte and read-data sides.
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] rx_byte_o,
  input wire logic rx_is_data_o,
  input wire logic rx_overrun_o,
  input wire logic read_arm_i,
  input wire logic tx_ready_o,
  input wire logic variant_3wire_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_variant_follow: assert property (
    (cs_n_i && $stable(bus_variant_strap_i)) [*5]
    |-> variant_3wire_o == bus_variant_strap_i)
    else $error("variant differs from strap");
  a_rx_in_frame: assert property (
    $rose(rx_valid_o) |-> !$past(cs_n_i, 4))
    else $error("byte received outside a frame");
  a_oe_cause: assert property (
    $rose(sda_oe_o) |-> read_arm_i && !cs_n_i)
    else $error("data line driven without a read");
  a_load_pulse: assert property (
    tx_ready_o |=> sda_oe_o && !tx_ready_o)
    else $error("read byte load malformed");
  a_sda_on_fall: assert property (
    sda_oe_o && $past(sda_oe_o) && $changed(sda_o) |-> !$past(sclk_i, 3))
    else $error("read bit changed off a falling edge");
  a_oe_release: assert property (
    cs_n_i [*6] |-> !sda_oe_o)
    else $error("data line held after deselect");
  a_rx_hold: assert property (
    rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_byte_o) && $stable(rx_is_data_o))
    else $error("queued byte changed while stalled");
  a_overrun_full: assert property (
    rx_overrun_o |-> $past(rx_valid_o && !rx_ready_i) ##1 !rx_overrun_o)
    else $error("overrun without a full queue");
endmodule : dshp_checker

bind dshp_top dshp_checker chk_u (
  .clk_i, .resetn_i, .sclk_i, .cs_n_i, .sda_o, .sda_oe_o,
  .bus_variant_strap_i, .rx_valid_o, .rx_ready_i, .rx_byte_o,
  .rx_is_data_o, .rx_overrun_o, .read_arm_i, .tx_ready_o, .variant_3wire_o
);
`default_nettype wire

// ==== dshp_host.sv ====
// Host microcontroller model driving the serial link.
`timescale 1ns/1ps
`default_nettype none

module dshp_host (
  // Core clock and the level on the data wire.
  input wire logic clk_i,
  input wire logic sda_i,
  // Link pins toward the port.
  output logic sclk_o,
  output logic cs_n_o,
  output logic dc_o,
  output logic sda_o
);
  // Half of a 160 ns link clock, inside the write rate limit.
  localparam int HALF = 16;
  // Read bits run at the slower read limit, one 400 ns period each.
  localparam int HALF_RD = dshp_pkg::SCLK_RD_MIN_CYC / 2;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dc_o = 1'b0;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // The link clock rests low around every change of chip select.
  task automatic sel(input logic on);
    wt(HALF);
    cs_n_o <= !on;
    wt(HALF);
  endtask : sel
  task automatic bits(input int n, input logic [8:0] v, input logic dc);
    dc_o <= dc;
    for (int i = n - 1; i >= 0; i--) begin
      sda_o <= v[i];
      wt(HALF);
      sclk_o <= 1'b1;
      wt(HALF);
      sclk_o <= 1'b0;
    end
    // Inverting the line keeps a stale bit from passing as valid.
    sda_o <= !sda_o;
    // One edge passes so a following call never sets the line again
    // in the same time step.
    wt(1);
  endtask : bits
  task automatic rd(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      wt(HALF_RD);
      sclk_o <= 1'b1;
      v[i] = sda_i;
      wt(HALF_RD);
      sclk_o <= 1'b0;
    end
  endtask : rd
endmodule : dshp_host
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the serial host port.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic strap = 1'b0;
  logic rx_ready_i = 1'b0;
  logic read_arm_i = 1'b0;
  logic [7:0] tx_byte_i = 8'h00;
  logic tx_valid_i = 1'b1;
  int n_load = 0;
  logic sclk, cs_n, dc, sda_h, sda_d, sda_oe, rx_valid, rx_is_data;
  logic rx_overrun, tx_ready, variant;
  logic [7:0] rx_byte, b;
  int n_fail = 0;
  int cmp_count = 0;
  int n_ovr = 0;
  wire logic sda_w = sda_oe ? sda_d : sda_h;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (rx_overrun === 1'b1) n_ovr <= n_ovr + 1;
  always @(posedge clk_i) if (tx_ready === 1'b1) n_load <= n_load + 1;

  dshp_top dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .dc_i(dc), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
    .bus_variant_strap_i(strap), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready_i), .rx_byte_o(rx_byte), .rx_is_data_o(rx_is_data),
    .rx_overrun_o(rx_overrun), .read_arm_i(read_arm_i),
    .tx_valid_i(tx_valid_i),
    .tx_byte_i(tx_byte_i), .tx_ready_o(tx_ready), .variant_3wire_o(variant)
  );
  dshp_host host_u (
    .clk_i(clk_i), .sda_i(sda_w), .sclk_o(sclk), .cs_n_o(cs_n), .dc_o(dc),
    .sda_o(sda_h)
  );

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Compares the head of the queue away from the edge, then pops it.
  task automatic take(input logic [8:0] exp);
    // A pop at the edge just passed must settle before the head is read.
    @(negedge clk_i);
    for (int i = 0; i < 200 && rx_valid !== 1'b1; i++) @(negedge clk_i);
    chk(rx_valid ? {rx_is_data, rx_byte} : 9'hXXX, exp);
    @(posedge clk_i) rx_ready_i <= 1'b1;
    @(posedge clk_i) rx_ready_i <= 1'b0;
  endtask : take
  task automatic t_wr4;
    host_u.sel(1'b1);
    host_u.bits(8, 9'h0A5, 1'b0);
    host_u.bits(8, 9'h03C, 1'b1);
    host_u.sel(1'b0);
    take(9'h0A5);
    take(9'h13C);
  endtask : t_wr4
  task automatic t_fifo;
    host_u.sel(1'b1);
    for (int i = 1; i <= 5; i++)
      host_u.bits(8, 9'(i), 1'b1);
    host_u.sel(1'b0);
    chk(9'(n_ovr), 9'h001);
    for (int i = 1; i <= 4; i++)
      take(9'h100 + 9'(i));
    @(negedge clk_i);
    chk({8'h00, rx_valid}, 9'h000);
  endtask : t_fifo
  task automatic t_rd4;
    host_u.sel(1'b1);
    host_u.bits(8, 9'h02E, 1'b0);
    take(9'h02E);
    read_arm_i <= 1'b1;
    tx_byte_i <= 8'h96;
    host_u.wt(16);
    host_u.bits(0, 9'h000, 1'b1);
    host_u.rd(b);
    chk({1'b0, b}, 9'h096);
    tx_byte_i <= 8'hA7;
    host_u.rd(b);
    chk({1'b0, b}, 9'h0A7);
    host_u.sel(1'b0);
    read_arm_i <= 1'b0;
    chk(9'(n_load), 9'h003);
  endtask : t_rd4
  task automatic t_wr3;
    host_u.bits(5, 9'h1FF, 1'b0);
    chk({8'h00, variant}, 9'h001);
    host_u.sel(1'b1);
    host_u.bits(9, 9'h05A, 1'b0);
    host_u.bits(9, 9'h1C3, 1'b0);
    host_u.bits(4, 9'h00F, 1'b0);
    host_u.sel(1'b0);
    take(9'h05A);
    take(9'h1C3);
    @(negedge clk_i);
    chk({8'h00, rx_valid}, 9'h000);
  endtask : t_wr3
  task automatic t_rd3;
    host_u.sel(1'b1);
    host_u.bits(9, 9'h02D, 1'b0);
    take(9'h02D);
    read_arm_i <= 1'b1;
    tx_byte_i <= 8'h3C;
    host_u.bits(1, 9'h001, 1'b0);
    host_u.rd(b);
    chk({1'b0, b}, 9'h03C);
    // An empty read side must still send a whole byte.
    tx_valid_i <= 1'b0;
    host_u.rd(b);
    chk({1'b0, b}, {1'b0, dshp_pkg::RD_FILL_BYTE});
    host_u.sel(1'b0);
    read_arm_i <= 1'b0;
    tx_valid_i <= 1'b1;
    chk(9'(n_load), 9'h006);
  endtask : t_rd3
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_wr4();
    t_fifo();
    t_rd4();
    strap <= 1'b1;
    t_wr3();
    t_rd3();
    close_out();
  end
  // The sequence needs some 31 us, so 200 us means a hang.
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
